// file: rtl/asie_regs.vh
// Constants for the ADC event flag and interrupt mask block.
// Assumes inclusion by its bare name from the design files.
//
// Summary of operation
// RL1 - Sequence-complete flag, bit 1, sets after one full sequence iteration.
// RL2 - Sequence-complete clears on flags read, launch write, or slot 52 wrap.
// RL3 - Conversion-ready flag, bit 0, sets on each new result; read clears.
// RL4 - Mask bits 23..16 gate channel 7..0 over-range flags onto interrupt.
// RL5 - Mask bits 15..8 gate channel 7..0 under-range flags onto interrupt.
// RL6 - Mask bit 7 gates the gain calibration over-range flag.
// RL7 - Mask bit 4 gates the unread-result flag.
// RL8 - Mask bit 3 gates the delay-finished flag.
// RL9 - Mask bit 2 gates the calibration-complete flag.
// RL10 - Mask bit 1 gates the sequence-complete flag.
// RL11 - Mask bit 0 resets to one; all other mask bits reset to zero.
// RL12 - Range flags set on violation and clear when the flags are read.
// RL13 - Delay-finished flag, bit 3, sets on wait done; read or write clears.
// RL14 - Unread-result flag, bit 4, mirrors unread data; read does not clear.
// RL15 - Interrupt is OR of flags AND mask; bits 6 and 5 read zero.
`ifndef ASIE_REGS_VH
`define ASIE_REGS_VH

// ----------------------------------------------------------------
// Register indexes and byte addresses
// ----------------------------------------------------------------
`define ASIE_IDX_FLAGS    8'h38
`define ASIE_IDX_MASK     8'h39
`define ASIE_IDX_WAITCLR  8'h3a
`define ASIE_ADDR_FLAGS   10'h0e0
`define ASIE_ADDR_MASK    10'h0e4
`define ASIE_ADDR_WAITCLR 10'h0e8

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ASIE_BIT_CONV     0
`define ASIE_BIT_SEQ      1
`define ASIE_BIT_CAL      2
`define ASIE_BIT_WAIT     3
`define ASIE_BIT_UNREAD   4
`define ASIE_BIT_SYSGOR   7
`define ASIE_LSB_UNDER    8
`define ASIE_LSB_OVER     16
`define ASIE_VALID_MASK   24'hffff9f
`define ASIE_MASK_RESET   24'h000001
`define ASIE_LAST_SLOT    6'h34

`endif

// file: rtl/asie_flag_bit.v
// One sticky event flag: set wins over clear.
// Assumes set and clear are one-cycle pulses on clk_sys.
`timescale 1ns/100ps
module asie_flag_bit (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire clk_en,
  input  wire set_pls,
  input  wire clr_pls,
  output reg  flag_r
);
  // Sticky flag update
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (clk_en) begin
      if (set_pls) begin
        flag_r <= 1'b1;
      end else if (clr_pls) begin
        flag_r <= 1'b0;
      end
    end
  end
endmodule

// file: rtl/asie_top.v
// Event flag register, interrupt mask and AXI4-Lite slave.
// Assumes event strobes are one-cycle pulses from logic on clk_sys.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "asie_regs.vh"
module asie_top #(
  parameter CHANNELS = 8
) (
  input  wire                  clk_sys,
  input  wire                  rst_n,
  input  wire                  clk_en,
  // Event strobes
  input  wire                  conv_done_pls,
  input  wire                  seq_iter_done_pls,
  input  wire                  seq_wrap_pls,
  input  wire                  seq_launch_wr_pls,
  input  wire                  cal_done_pls,
  input  wire                  wait_done_pls,
  input  wire                  sysgor_pls,
  input  wire [CHANNELS-1:0]   over_range_pls,
  input  wire [CHANNELS-1:0]   under_range_pls,
  input  wire                  unread_result,
  output reg                   irq_r,
  // AXI4-Lite
  input  wire [9:0]            s_axi_awaddr,
  input  wire [2:0]            s_axi_awprot,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [9:0]            s_axi_araddr,
  input  wire [2:0]            s_axi_arprot,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [1:0] RESP_OKAY   = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;

  reg  [9:0]  aw_addr_r;
  reg         aw_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_held_r;
  reg  [23:0] mask_r;
  reg  [23:0] mask_nxt;
  wire [23:0] flags;
  wire [23:0] set_vec;
  wire [23:0] clr_vec;
  wire        wr_go;
  wire        rd_go;
  wire        rd_flags;
  wire        wr_waitclr;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  // Address and data are taken independently, in either order
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 10'h000;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held_r && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_r && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end
    end
  end

  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

  // Write response after both halves are in
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r[9:2] == `ASIE_IDX_MASK ||
            aw_addr_r[9:2] == `ASIE_IDX_WAITCLR ||
            aw_addr_r[9:2] == `ASIE_IDX_FLAGS) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask register
  // ----------------------------------------------------------------
  // Byte-lane merge; reserved bits never store
  always @* begin
    mask_nxt = mask_r;
    if (wr_go && aw_addr_r[9:2] == `ASIE_IDX_MASK) begin
      if (w_strb_r[0]) mask_nxt[7:0]   = w_data_r[7:0];
      if (w_strb_r[1]) mask_nxt[15:8]  = w_data_r[15:8];
      if (w_strb_r[2]) mask_nxt[23:16] = w_data_r[23:16];
    end
    mask_nxt = mask_nxt & `ASIE_VALID_MASK; // [RL15]
  end

  // Mask storage; only bit 0 resets to one
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= `ASIE_MASK_RESET; // [RL11]
    end else if (clk_en) begin
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign rd_go    = s_axi_arvalid && s_axi_arready;
  assign rd_flags = rd_go && s_axi_araddr[9:2] == `ASIE_IDX_FLAGS;

  // Address ready, then data one cycle later
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr[9:2])
          `ASIE_IDX_FLAGS: begin
            s_axi_rdata <= {8'h00, flags & `ASIE_VALID_MASK}; // [RL15]
          end
          `ASIE_IDX_MASK: begin
            s_axi_rdata <= {8'h00, mask_r};
          end
          `ASIE_IDX_WAITCLR: begin
            s_axi_rdata <= 32'h00000000;
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  assign wr_waitclr = wr_go && aw_addr_r[9:2] == `ASIE_IDX_WAITCLR;

  // Set sources per bit
  assign set_vec[`ASIE_BIT_CONV]   = conv_done_pls;      // [RL3]
  assign set_vec[`ASIE_BIT_SEQ]    = seq_iter_done_pls;  // [RL1]
  assign set_vec[`ASIE_BIT_CAL]    = cal_done_pls;
  assign set_vec[`ASIE_BIT_WAIT]   = wait_done_pls;      // [RL13]
  assign set_vec[`ASIE_BIT_UNREAD] = 1'b0;
  assign set_vec[6:5]              = 2'b00;
  assign set_vec[`ASIE_BIT_SYSGOR] = sysgor_pls;
  assign set_vec[15:8]             = under_range_pls;    // [RL12]
  assign set_vec[23:16]            = over_range_pls;     // [RL12]

  // Clear sources per bit; a read clears all sticky flags
  assign clr_vec[`ASIE_BIT_CONV]   = rd_flags;           // [RL3]
  assign clr_vec[`ASIE_BIT_SEQ]    = rd_flags || seq_launch_wr_pls ||
                                     seq_wrap_pls;       // [RL2]
  assign clr_vec[`ASIE_BIT_CAL]    = rd_flags;
  assign clr_vec[`ASIE_BIT_WAIT]   = rd_flags || wr_waitclr; // [RL13]
  assign clr_vec[`ASIE_BIT_UNREAD] = 1'b0;
  assign clr_vec[6:5]              = 2'b00;
  assign clr_vec[`ASIE_BIT_SYSGOR] = rd_flags;
  assign clr_vec[15:8]             = {8{rd_flags}};      // [RL12]
  assign clr_vec[23:16]            = {8{rd_flags}};      // [RL12]

  // One sticky cell per flag; unread-result is a live level instead
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1) begin : g_flag
      if (gi == `ASIE_BIT_UNREAD) begin : g_live
        assign flags[gi] = unread_result; // [RL14]
      end else if (gi == 5 || gi == 6) begin : g_rsvd
        assign flags[gi] = 1'b0; // [RL15]
      end else begin : g_sticky
        asie_flag_bit u_flag (
          .clk_sys (clk_sys),
          .rst_n   (rst_n),
          .clk_en  (clk_en),
          .set_pls (set_vec[gi]),
          .clr_pls (clr_vec[gi]),
          .flag_r  (flags[gi])
        );
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Each flag gated by its mask bit, all ORed together
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else if (clk_en) begin
      irq_r <= |(flags & mask_r); // [RL4] [RL5] [RL6] [RL7] [RL8] [RL9] [RL10] [RL15]
    end
  end

endmodule

// file: dv/asie_sva.sv
// Port assertions for the event flag block.
// Assumes binding to asie_top; one clock domain.
`timescale 1ns/100ps
module asie_sva #(
  parameter CHANNELS = 8
) (
  input wire                clk_sys,
  input wire                rst_n,
  input wire                conv_done_pls,
  input wire                seq_iter_done_pls,
  input wire                cal_done_pls,
  input wire                wait_done_pls,
  input wire                sysgor_pls,
  input wire [CHANNELS-1:0] over_range_pls,
  input wire [CHANNELS-1:0] under_range_pls,
  input wire                unread_result,
  input wire                irq_r,
  input wire [1:0]          s_axi_bresp,
  input wire                s_axi_bvalid,
  input wire                s_axi_bready,
  input wire                s_axi_arready,
  input wire [31:0]         s_axi_rdata,
  input wire [1:0]          s_axi_rresp,
  input wire                s_axi_rvalid,
  input wire                s_axi_rready
);
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  // Any source that may raise a flag
  wire ev_any = conv_done_pls | seq_iter_done_pls | cal_done_pls |
                wait_done_pls | sysgor_pls | (|over_range_pls) |
                (|under_range_pls) | unread_result;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  irq_cause_a : assert property (
    $rose(irq_r) |-> $past(ev_any) || $past(ev_any, 2) || $past(s_axi_bvalid))
    else $error("irq rose without event or mask write");
  rdata_resv_a : assert property (
    s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h0 && s_axi_rdata[6:5] == 2'h0)
    else $error("reserved read bits not zero");
  rresp_code_a : assert property (s_axi_rvalid |-> !s_axi_rresp[0])
    else $error("illegal read response");
  bresp_code_a : assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("illegal write response");
  rdata_hold_a : assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  bvalid_hold_a : assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  arready_once_a : assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  ar_block_a : assert property (s_axi_arready |-> !s_axi_rvalid)
    else $error("read taken while response pending");
endmodule
bind asie_top asie_sva #(.CHANNELS(CHANNELS)) u_sva (.*);

// file: dv/asie_evt_model.sv
// Event source model standing in for converter and sequencer logic.
// Assumes the bench requests each event for one cycle.
`timescale 1ns/100ps
module asie_evt_model (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [25:0] ev_req,
  output reg  [25:0] ev_pls_r,
  output reg         unread_r
);
  // One-cycle strobe per request
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ev_pls_r <= 26'h0;
      unread_r <= 1'b0;
    end else begin
      ev_pls_r <= ev_req;
      // Unread data appears, later consumed
      if (ev_req[4])
        unread_r <= 1'b1;
      else if (ev_req[5])
        unread_r <= 1'b0;
    end
  end
endmodule

// file: dv/test_adc_status_irq_enable.sv
// Self-checking bench for the event flag block.
// Assumes asie_regs.vh on the include path.
`timescale 1ns/100ps
`include "asie_regs.vh"
module test_adc_status_irq_enable;
  reg          clk_sys = 1'b0;
  reg          rst_n = 1'b0;
  reg          clk_en = 1'b1;
  reg  [25:0]  ev = 26'h0;
  reg  [9:0]   awaddr = 10'h0, araddr = 10'h0;
  reg  [31:0]  wdata = 32'h0, rnd = 32'hffc3024d;
  reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg          arvalid = 1'b0, rready = 1'b0;
  reg  [23:0]  m;
  wire [25:0]  pls;
  wire         unread, irq_r, awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  integer      n_mismatch = 0, num_checks = 0, i;
  logic [33:0] exp_q[$];
  logic [1:0]  bexp_q[$];
  // -------------------------------------------------------------
  // Clock, models, design
  // -------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;
  asie_evt_model u_model (.clk_sys(clk_sys), .rst_n(rst_n), .ev_req(ev),
    .ev_pls_r(pls), .unread_r(unread));
  asie_top u_asie_top (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .conv_done_pls(pls[0]), .seq_iter_done_pls(pls[1]),
    .seq_wrap_pls(pls[24]), .seq_launch_wr_pls(pls[25]),
    .cal_done_pls(pls[2]), .wait_done_pls(pls[3]), .sysgor_pls(pls[7]),
    .over_range_pls(pls[23:16]), .under_range_pls(pls[15:8]),
    .unread_result(unread), .irq_r(irq_r), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input [33:0] e, input [33:0] s);
    num_checks = num_checks + 1;
    if (e !== s) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  // Bus write; a random late bready makes the slave hold its response
  task automatic wr(input [9:0] a, input [31:0] d, input [1:0] r);
    reg late;
    rnd = lfsr(rnd);
    late = rnd[1];
    bexp_q.push_back(r);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !late;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    if (late) begin
      bready <= 1'b1;
      @(posedge clk_sys);
    end
    bready <= 1'b0;
  endtask
  // Bus read; the monitor compares against the noted value
  task automatic rd(input [9:0] a, input [33:0] e);
    reg late;
    rnd = lfsr(rnd);
    late = rnd[0];
    exp_q.push_back(e);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !late;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    if (late) begin
      rready <= 1'b1;
      @(posedge clk_sys);
    end
    rready <= 1'b0;
  endtask
  // Request events, then let flag and irq settle
  task automatic fire(input [25:0] v);
    @(posedge clk_sys);
    ev <= v;
    @(posedge clk_sys);
    ev <= 26'h0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic irq_is(input e);
    chk("irq", {33'h0, e}, {33'h0, irq_r});
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Read monitor
  always @(posedge clk_sys)
    if (rvalid === 1'b1 && rready === 1'b1)
      chk("rdata", exp_q.pop_front(), {rresp, rdata});
  // Write response monitor
  always @(posedge clk_sys)
    if (bvalid === 1'b1 && bready === 1'b1)
      chk("bresp", {32'h0, bexp_q.pop_front()}, {32'h0, bresp});
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`ASIE_ADDR_MASK, 34'h1);
    rd(`ASIE_ADDR_FLAGS, 34'h0);
    rd(10'h0f0, {2'b10, 32'h0});
    wr(10'h0f0, 32'hffffffff, 2'b10);
    wr(`ASIE_ADDR_MASK, 32'hffffffff, 2'b00);
    rd(`ASIE_ADDR_MASK, 34'hffff9f);
    for (i = 0; i < 24; i = i + 1) begin
      if (i < 4 || i > 6) begin
        rnd = lfsr(rnd);
        m = rnd[23:0] & 24'hffff8f;
        m[i] = i[0];
        wr(`ASIE_ADDR_MASK, {8'h0, m}, 2'b00);
        fire(26'h1 << i);
        irq_is(m[i]);
        rd(`ASIE_ADDR_FLAGS, 34'h1 << i);
        rd(`ASIE_ADDR_FLAGS, 34'h0);
        irq_is(1'b0);
      end
    end
    wr(`ASIE_ADDR_MASK, 32'h12, 2'b00);
    fire(26'h2);
    fire(26'h2000000);
    irq_is(1'b0);
    fire(26'h2);
    fire(26'h1000000);
    rd(`ASIE_ADDR_FLAGS, 34'h0);
    fire(26'h2000002);
    rd(`ASIE_ADDR_FLAGS, 34'h2);
    fire(26'h8);
    wr(`ASIE_ADDR_WAITCLR, 32'h0, 2'b00);
    rd(`ASIE_ADDR_FLAGS, 34'h0);
    fire(26'h1);
    wr(`ASIE_ADDR_FLAGS, 32'h0, 2'b00);
    rd(`ASIE_ADDR_FLAGS, 34'h1);
    fire(26'h10);
    irq_is(1'b1);
    rd(`ASIE_ADDR_FLAGS, 34'h10);
    rd(`ASIE_ADDR_FLAGS, 34'h10);
    fire(26'h20);
    irq_is(1'b0);
    // Events offered while frozen must leave no flag behind
    clk_en <= 1'b0;
    fire(26'h1);
    clk_en <= 1'b1;
    rd(`ASIE_ADDR_FLAGS, 34'h0);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`ASIE_ADDR_MASK, 34'h1);
    report_and_stop;
  end
endmodule
